// *** design/sleep_gate_regs.svh ***
// register offsets, field positions, reset values for the sleep clock gating block
`ifndef SLEEP_GATE_REGS_SVH
`define SLEEP_GATE_REGS_SVH
`define RUN_GATE_OFFSET 12'h104
`define SLEEP_GATE_OFFSET 12'h114
`define DEEP_GATE_OFFSET 12'h124
`define MODE_CTRL_OFFSET 12'h1f0
`define GATE_RESET 32'h00000000
`define GATE_IMPL_MASK 32'h01071013
`define MODE_CTRL_RESET 32'h00000000
`define BIT_COMPARATOR_ZERO 24
`define BIT_GP_COUNTER_TWO 18
`define BIT_GP_COUNTER_ONE 17
`define BIT_GP_COUNTER_ZERO 16
`define BIT_TWO_WIRE_ZERO 12
`define BIT_SYNC_SERIAL_ZERO 4
`define BIT_ASYNC_SERIAL_ONE 1
`define BIT_ASYNC_SERIAL_ZERO 0
`define MODE_AUTO_GATE_BIT 0
`define NUM_UNITS 8
`endif

// *** design/sleep_gate_pkg.sv ***
// types for the sleep clock gating block
package sleep_gate_pkg;
  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_SLEEP = 3'b010,
    PWR_DEEP = 3'b100
  } power_mode_e;

  typedef struct packed {
    logic comparator_zero_gate;
    logic gp_counter_two_gate;
    logic gp_counter_one_gate;
    logic gp_counter_zero_gate;
    logic two_wire_zero_gate;
    logic sync_serial_zero_gate;
    logic async_serial_one_gate;
    logic async_serial_zero_gate;
  } unit_gate_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } wb_req_s;
endpackage

// *** design/unit_access_guard.sv ***
// per-unit access guard: answers a unit bus request with a fault when the unit is gated
`timescale 1ns/10ps
module unit_access_guard
  import sleep_gate_pkg::*;
#(
  parameter int N = 8
) (
  input wire logic [N-1:0] clk_en,
  input wire logic [N-1:0] unit_req,
  input wire logic [N-1:0] unit_ack_in,
  output logic [N-1:0] unit_req_out,
  output logic [N-1:0] unit_ack_out,
  output logic [N-1:0] unit_err_out
);
  // elaboration check: at least one guarded unit
  if (N < 1) begin : g_bad_n
    $error("unit_access_guard needs at least one unit");
  end

  // gated unit never sees the request; it is answered with an error instead
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_guard
      assign unit_req_out[g] = unit_req[g] & clk_en[g];
      assign unit_ack_out[g] = unit_ack_in[g] & clk_en[g];
      assign unit_err_out[g] = unit_req[g] & ~clk_en[g];
    end
  endgenerate
endmodule

// *** design/sleep_clock_gating_reg.sv ***
// sleep mode clock gating register with run and deep sleep companions and unit access guard
//
// Behaviour
// - set bit clocks unit, clear bit disables it
// - access to gated unit gives bus fault
// - all gating bits reset to zero
// - run, sleep, deep sleep each own register
// - sleep settings apply only with auto gating
// - bit 24 gates analog comparator zero
// - bits 18,17,16 gate counters two,one,zero
// - bit 12 gates two-wire controller zero
// - bit 4 gates synchronous serial port zero
// - bits 1,0 gate async serial one, zero
// - reserved bits read zero, software preserves them
`timescale 1ns/10ps
`include "sleep_gate_regs.svh"
module sleep_clock_gating_reg
  import sleep_gate_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  output logic [2:0] power_mode,
  output logic [7:0] unit_clk_en,
  input wire logic [7:0] unit_req,
  input wire logic [7:0] unit_ack_in,
  output logic [7:0] unit_req_out,
  output logic [7:0] unit_ack_out,
  output logic [7:0] unit_err_out
);
  if (ADDR_W != 12) begin : g_bad_addr_w
    $error("sleep_clock_gating_reg supports a 12-bit byte address only");
  end

  logic [31:0] run_gate_ff;
  logic [31:0] sleep_gate_ff;
  logic [31:0] deep_gate_ff;
  logic [31:0] mode_ctrl_ff;
  logic ack_ff;
  logic err_ff;
  logic [31:0] rdata_ff;
  power_mode_e mode_ff;
  power_mode_e nxt_mode;
  logic [31:0] byte_mask;
  logic [31:0] nxt_rdata;
  logic hit_run;
  logic hit_sleep;
  logic hit_deep;
  logic hit_mode;
  logic hit_any;
  logic req;
  logic wr;
  logic [31:0] active_gate;
  unit_gate_s gate_view;

  // new request: cycle with strobe, not yet answered
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
  assign wr = req & wb_we_i;

  // address decoding
  always_comb begin
    hit_run = 1'b0;
    hit_sleep = 1'b0;
    hit_deep = 1'b0;
    hit_mode = 1'b0;
    if (wb_adr_i == `RUN_GATE_OFFSET) begin
      hit_run = 1'b1;
    end else if (wb_adr_i == `SLEEP_GATE_OFFSET) begin
      hit_sleep = 1'b1;
    end else if (wb_adr_i == `DEEP_GATE_OFFSET) begin
      hit_deep = 1'b1;
    end else if (wb_adr_i == `MODE_CTRL_OFFSET) begin
      hit_mode = 1'b1;
    end
  end
  assign hit_any = hit_run | hit_sleep | hit_deep | hit_mode;

  // byte lanes expanded to a 32-bit mask, not yet limited to implemented bits
  always_comb begin
    byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  // run mode gating register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_gate_ff <= `GATE_RESET;
    end else if (wr && hit_run) begin
      run_gate_ff <= (run_gate_ff & ~(byte_mask & `GATE_IMPL_MASK))
                   | (wb_dat_i & byte_mask & `GATE_IMPL_MASK);
    end
  end

  // sleep mode gating register, the main register of this block
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_gate_ff <= `GATE_RESET;
    end else if (wr && hit_sleep) begin
      sleep_gate_ff <= (sleep_gate_ff & ~(byte_mask & `GATE_IMPL_MASK))
                     | (wb_dat_i & byte_mask & `GATE_IMPL_MASK);
    end
  end

  // deep sleep gating register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_gate_ff <= `GATE_RESET;
    end else if (wr && hit_deep) begin
      deep_gate_ff <= (deep_gate_ff & ~(byte_mask & `GATE_IMPL_MASK))
                    | (wb_dat_i & byte_mask & `GATE_IMPL_MASK);
    end
  end

  // mode control: bit 0 is auto_clock_gating_enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctrl_ff <= `MODE_CTRL_RESET;
    end else if (wr && hit_mode && wb_sel_i[0]) begin
      mode_ctrl_ff[`MODE_AUTO_GATE_BIT] <= wb_dat_i[`MODE_AUTO_GATE_BIT];
    end
  end

  // power mode tracking from the sleep request inputs
  always_comb begin
    nxt_mode = PWR_RUN;
    if (deep_sleep_req) begin
      nxt_mode = PWR_DEEP;
    end else if (sleep_req) begin
      nxt_mode = PWR_SLEEP;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= PWR_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // pick the gating register for the current mode; sleep ones need auto gating
  always_comb begin
    active_gate = run_gate_ff;
    case (mode_ff)
      PWR_RUN: active_gate = run_gate_ff;
      PWR_SLEEP: begin
        if (mode_ctrl_ff[`MODE_AUTO_GATE_BIT]) begin
          active_gate = sleep_gate_ff;
        end
      end
      PWR_DEEP: begin
        if (mode_ctrl_ff[`MODE_AUTO_GATE_BIT]) begin
          active_gate = deep_gate_ff;
        end
      end
      default: active_gate = run_gate_ff;
    endcase
  end

  // map register bits onto the per-unit enables
  always_comb begin
    gate_view.comparator_zero_gate = active_gate[`BIT_COMPARATOR_ZERO];
    gate_view.gp_counter_two_gate = active_gate[`BIT_GP_COUNTER_TWO];
    gate_view.gp_counter_one_gate = active_gate[`BIT_GP_COUNTER_ONE];
    gate_view.gp_counter_zero_gate = active_gate[`BIT_GP_COUNTER_ZERO];
    gate_view.two_wire_zero_gate = active_gate[`BIT_TWO_WIRE_ZERO];
    gate_view.sync_serial_zero_gate = active_gate[`BIT_SYNC_SERIAL_ZERO];
    gate_view.async_serial_one_gate = active_gate[`BIT_ASYNC_SERIAL_ONE];
    gate_view.async_serial_zero_gate = active_gate[`BIT_ASYNC_SERIAL_ZERO];
  end

  // registered clock enables to the units
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_clk_en <= 8'h00;
    end else begin
      unit_clk_en <= gate_view;
    end
  end

  // read data mux, reserved bits zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (hit_run) begin
      nxt_rdata = run_gate_ff & `GATE_IMPL_MASK;
    end else if (hit_sleep) begin
      nxt_rdata = sleep_gate_ff & `GATE_IMPL_MASK;
    end else if (hit_deep) begin
      nxt_rdata = deep_gate_ff & `GATE_IMPL_MASK;
    end else if (hit_mode) begin
      nxt_rdata = {31'h00000000, mode_ctrl_ff[`MODE_AUTO_GATE_BIT]};
    end
  end

  // bus answer: one wait state, ack for mapped, err for unmapped
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      ack_ff <= req & hit_any;
      err_ff <= req & ~hit_any;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff & wb_cyc_i & wb_stb_i;
  assign wb_err_o = err_ff & wb_cyc_i & wb_stb_i;
  assign wb_dat_o = rdata_ff;
  assign power_mode = mode_ff;

  // fault for accesses to units whose clock is off
  unit_access_guard #(
    .N(`NUM_UNITS)
  ) u_guard (
    .clk_en(unit_clk_en),
    .unit_req(unit_req),
    .unit_ack_in(unit_ack_in),
    .unit_req_out(unit_req_out),
    .unit_ack_out(unit_ack_out),
    .unit_err_out(unit_err_out)
  );
endmodule

// *** tb/sleep_clock_gating_reg_monitor.sv ***
// port assertions for the sleep clock gating register
`timescale 1ns/10ps
module sleep_clock_gating_reg_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [7:0] unit_clk_en,
  input wire logic [7:0] unit_req,
  input wire logic [7:0] unit_ack_in,
  input wire logic [7:0] unit_req_out,
  input wire logic [7:0] unit_ack_out,
  input wire logic [7:0] unit_err_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a bus request still waiting for its answer
  wire logic pend = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  // bus timing, register map and unit gating relations
  a_answer_next: assert property (pend |=> wb_ack_o || wb_err_o) else $error("no answer");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_sleep_mapped: assert property (pend && wb_adr_i == 12'h114 |=> wb_ack_o)
    else $error("sleep register not mapped");
  a_rsv_zero: assert property (wb_ack_o && wb_adr_i == 12'h114 |->
    (wb_dat_o & ~32'h01071013) == 32'h0) else $error("reserved bits set");
  a_fault_gated: assert property (unit_err_out == (unit_req & ~unit_clk_en))
    else $error("fault mismatch");
  a_req_pass: assert property (unit_req_out == (unit_req & unit_clk_en))
    else $error("request pass mismatch");
  a_ack_pass: assert property (unit_ack_out == (unit_ack_in & unit_clk_en))
    else $error("ack pass mismatch");
  a_reset_off: assert property ($rose(rst_n) |-> unit_clk_en == 8'h0)
    else $error("units clocked after reset");
  // main scenarios
  cover property (wb_err_o);
  cover property (wb_ack_o && wb_adr_i == 12'h114);
  cover property (|unit_err_out);
  cover property (|unit_clk_en);
endmodule
bind sleep_clock_gating_reg sleep_clock_gating_reg_monitor mon_u (.core_clk(core_clk),
  .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .unit_clk_en(unit_clk_en),
  .unit_req(unit_req), .unit_ack_in(unit_ack_in), .unit_req_out(unit_req_out),
  .unit_ack_out(unit_ack_out), .unit_err_out(unit_err_out));

// *** tb/sleep_clock_gating_reg_tb.sv ***
// self-checking bench for the sleep clock gating register
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module sleep_clock_gating_reg_tb
  import sleep_gate_pkg::*;
;
  logic core_clk = 0, rst_n = 0, sleep_req = 0, deep_sleep_req = 0, er, wb_ack_o, wb_err_o;
  wb_req_s q = '0;
  logic [31:0] wb_dat_o, rd, d, sh, rv[3];
  logic [2:0] power_mode;
  logic [7:0] unit_clk_en, unit_req = 0, unit_ack_in = 0;
  logic [7:0] unit_req_out, unit_ack_out, unit_err_out;
  logic [3:0] sl;
  int errors = 0, samples_checked = 0, seed = 67;
  int pos[8] = '{0, 1, 4, 12, 16, 17, 18, 24};
  sleep_clock_gating_reg dut_u (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(q.cyc),
    .wb_stb_i(q.stb), .wb_we_i(q.we), .wb_sel_i(q.sel), .wb_adr_i(q.adr), .wb_dat_i(q.dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .power_mode(power_mode), .unit_clk_en(unit_clk_en),
    .unit_req(unit_req), .unit_ack_in(unit_ack_in), .unit_req_out(unit_req_out),
    .unit_ack_out(unit_ack_out), .unit_err_out(unit_err_out));
  // clock generator
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // count report and verdict
  task automatic conclude();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one classic cycle, held until ack or err, then one idle cycle
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] dd,
    input logic [3:0] s);
    int n;
    n = 0;
    q <= {1'b1, 1'b1, w, s, a, dd};
    do begin
      @(posedge core_clk);
      n++;
    end while ((wb_ack_o | wb_err_o) !== 1'b1 && n < 20);
    if ((wb_ack_o | wb_err_o) !== 1'b1) begin
      errors++;
      conclude();
    end
    rd = wb_dat_o;
    er = wb_err_o;
    q <= '0;
    @(posedge core_clk);
  endtask
  // enable bits in unit order
  function automatic logic [7:0] en(input logic [31:0] x);
    return {x[24], x[18:16], x[12], x[4], x[1:0]};
  endfunction
  // lane merge of a write, reserved bits dropped
  function automatic logic [31:0] mrg(input logic [31:0] o, n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i+:8] = n[8*i+:8];
    return o & 32'h01071013;
  endfunction
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    wb(0, 12'h114, 0, 4'hf);
    `CHK(rd, 32'h0)
    `CHK(unit_clk_en, 8'h0)
    sh = 0;
    for (int i = 0; i < 40; i++) begin
      d = (i == 0) ? 32'hffffffff : $random(seed);
      sl = (i < 2) ? 4'hf : 4'($random(seed));
      wb(1, 12'h114, d, sl);
      sh = mrg(sh, d, sl);
      wb(0, 12'h114, 0, 4'h0);
      `CHK(rd, sh)
      `CHK(er, 1'b0)
    end
    for (int k = 0; k < 8; k++) begin
      unit_req <= 8'($random(seed));
      unit_ack_in <= 8'($random(seed));
      wb(1, 12'h104, 32'h1 << pos[k], 4'hf);
      `CHK(unit_clk_en, 8'h1 << k)
      `CHK(unit_err_out, unit_req & ~(8'h1 << k))
      `CHK(unit_req_out, unit_req & (8'h1 << k))
      `CHK(unit_ack_out, unit_ack_in & (8'h1 << k))
    end
    wb(1, 12'h200, 32'hffffffff, 4'hf);
    `CHK(er, 1'b1)
    wb(0, 12'h114, 0, 4'hf);
    `CHK(rd, sh)
    for (int m = 0; m < 3; m++) begin
      rv[m] = $random(seed);
      wb(1, 12'h104 + 12'(16 * m), rv[m], 4'hf);
      wb(0, 12'h104 + 12'(16 * m), 0, 4'hf);
      `CHK(rd, rv[m] & 32'h01071013)
    end
    for (int g = 0; g < 2; g++) begin
      wb(1, 12'h1f0, 32'(g), 4'hf);
      wb(0, 12'h1f0, 0, 4'hf);
      `CHK(rd, 32'(g))
      for (int m = 0; m < 3; m++) begin
        sleep_req <= (m == 1);
        deep_sleep_req <= (m == 2);
        repeat (3) @(posedge core_clk);
        `CHK(power_mode, 3'b001 << m)
        `CHK(unit_clk_en, en((g == 1) ? rv[m] : rv[0]))
      end
    end
    rst_n <= 0;
    @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    wb(0, 12'h114, 0, 4'hf);
    `CHK(rd, 32'h0)
    `CHK(unit_clk_en, 8'h0)
    conclude();
  end
endmodule
